// ### rtl/sdc_config_regs.sv
/*
 * Run, interface and general configuration registers behind the serial
 * port, with frame error checking, dimming cycle generation and clock pin
 * control. Assumes a same-clock serial front end that pulses frame_done_in
 * with the frame's decoded fields, and sibling blocks that claim their own
 * addresses through addr_claimed_in.
 */
`timescale 1ns/1ps
module sdc_config_regs #(
    parameter int DIM_LOG2 = sdc_pkg::DIM_BASE_LOG2,
    parameter int EXT_LIMIT = sdc_pkg::EXT_LIMIT_CYCLES
) (
    input wire logic mclk_in, // Device clock, 40 MHz
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic frame_done_in, // Frame finished strobe
    input wire logic [sdc_pkg::EDGE_W-1:0] frame_edges_in, // Clock edges seen
    input wire logic frame_crc_ok_in, // CRC check passed
    input wire logic frame_write_in, // Write when high
    input wire logic frame_cluster_in, // Cluster-addressed frame
    input wire logic [sdc_pkg::CID_W-1:0] frame_cid_in, // Received cluster id
    input wire logic [sdc_pkg::ADDR_W-1:0] frame_addr_in, // Register address
    input wire logic [sdc_pkg::DATA_W-1:0] frame_data_in, // Data field
    input wire logic addr_claimed_in, // Address owned elsewhere
    input wire logic ext_clk_pin_in, // CLK pin input level
    output logic frame_accept_out, // Frame taken pulse
    output logic rd_valid_out, // Read data valid pulse
    output logic [sdc_pkg::DATA_W-1:0] rd_data_out, // Read data
    output logic [sdc_pkg::CID_W-1:0] cluster_ident_out, // Stored cluster id
    output logic chip_select_pullup_en_out, // Pull-up on chip_select_n
    output logic sclk_pulldown_en_out, // Pull-down on serial clock
    output logic serial_in_pulldown_en_out, // Pull-down on serial data in
    output logic spi_err_out, // Summary error
    output logic fault_threshold_select_out, // Short threshold select
    output logic [sdc_pkg::SLEW_W-1:0] gate_slew_select_out, // Applied slew
    output logic [sdc_pkg::DIV_W-1:0] dim_div_out, // Divider code
    output logic [sdc_pkg::SRC_W-1:0] clk_src_out, // Clock source code
    output logic clk_pin_out, // CLK pin drive value
    output logic clk_pin_oe_out, // CLK pin output enable
    output logic switch_run_enable_out, // Switches follow program
    output logic dim_cycle_out, // Dimming period end pulse
    output logic config_pending_out, // General config pending
    output logic external_clock_slow_out // External clock too slow
);
    import sdc_pkg::*;
    localparam int DIM_W = DIM_LOG2 + DIV_W + 2;
    function automatic logic is_ours(input logic [ADDR_W-1:0] addr);
        is_ours = (addr == ADDR_RUN) || (addr == ADDR_IFC) || (addr == ADDR_GEN);
    endfunction
    function automatic logic [DIM_W-1:0] dim_last(input logic [DIV_W-1:0] div);
        dim_last = ({{(DIM_W-1){1'b0}}, 1'b1} << (DIM_LOG2 + int'(div))) - 1'b1;
    endfunction

    // Frame checks
    logic [CID_W-1:0] cid_d, cid_q;
    logic edges_bad, crc_bad, cid_miss, known, live;
    logic evt_clk, evt_crc, evt_wr, evt_rd, acc, acc_wr, acc_rd, clr;
    always_comb
    begin
        edges_bad = (frame_edges_in != FRAME_EDGES);
        crc_bad = ~frame_crc_ok_in;
        cid_miss = frame_cluster_in && (frame_cid_in != cid_q);
        known = is_ours(frame_addr_in) || addr_claimed_in;
        evt_clk = frame_done_in && edges_bad;
        evt_crc = frame_done_in && !edges_bad && crc_bad;
        // Mismatched cluster frames are dropped silently, no flag raised
        live = frame_done_in && !edges_bad && !crc_bad && !cid_miss;
        evt_wr = live && (frame_write_in ? !known : (frame_data_in != '0));
        evt_rd = live && !frame_write_in && (frame_data_in == '0) && !known;
        acc = live && !evt_wr && !evt_rd;
        acc_wr = acc && frame_write_in && is_ours(frame_addr_in);
        acc_rd = acc && !frame_write_in && is_ours(frame_addr_in);
        clr = acc_rd && (frame_addr_in == ADDR_IFC);
    end

    // Interface and run registers
    logic cs_pu_d, cs_pu_q, sclk_pd_d, sclk_pd_q, sdi_pd_d, sdi_pd_q;
    logic clk_err_d, clk_err_q, crc_err_d, crc_err_q;
    logic wr_err_d, wr_err_q, rd_err_d, rd_err_q;
    logic spi_err_d, spi_err_q, run_d, run_q;
    always_comb
    begin
        cid_d = cid_q;
        cs_pu_d = cs_pu_q;
        sclk_pd_d = sclk_pd_q;
        sdi_pd_d = sdi_pd_q;
        run_d = run_q;
        if (acc_wr && frame_addr_in == ADDR_IFC)
        begin
            cid_d = frame_data_in[IFC_CID_LSB +: CID_W];
            cs_pu_d = frame_data_in[IFC_CS_BIT];
            sclk_pd_d = frame_data_in[IFC_SCLK_BIT];
            sdi_pd_d = frame_data_in[IFC_SDI_BIT];
        end
        if (acc_wr && frame_addr_in == ADDR_RUN)
            run_d = frame_data_in[RUN_EN_BIT];
        // Set terms applied after the clear so a fresh event survives
        clk_err_d = (clk_err_q && !clr) || evt_clk;
        crc_err_d = (crc_err_q && !clr) || evt_crc;
        wr_err_d = (wr_err_q && !clr) || evt_wr;
        rd_err_d = (rd_err_q && !clr) || evt_rd;
        spi_err_d = clk_err_d | crc_err_d | wr_err_d | rd_err_d;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cid_q <= CID_RST;
            cs_pu_q <= PULL_RST;
            sclk_pd_q <= PULL_RST;
            sdi_pd_q <= PULL_RST;
            clk_err_q <= 1'b0;
            crc_err_q <= 1'b0;
            wr_err_q <= 1'b0;
            rd_err_q <= 1'b0;
            spi_err_q <= 1'b0;
            run_q <= RUN_RST;
        end
        else if (ce_in)
        begin
            cid_q <= cid_d;
            cs_pu_q <= cs_pu_d;
            sclk_pd_q <= sclk_pd_d;
            sdi_pd_q <= sdi_pd_d;
            clk_err_q <= clk_err_d;
            crc_err_q <= crc_err_d;
            wr_err_q <= wr_err_d;
            rd_err_q <= rd_err_d;
            spi_err_q <= spi_err_d;
            run_q <= run_d;
        end
    end

    // General register, applied slew and pending flag
    logic vth_d, vth_q, pend_d, pend_q;
    logic [SLEW_W-1:0] slew_d, slew_q, slew_act_d, slew_act_q;
    logic [DIV_W-1:0] div_d, div_q;
    logic [SRC_W-1:0] src_d, src_q;
    logic dim_tick;
    always_comb
    begin
        vth_d = vth_q;
        slew_d = slew_q;
        div_d = div_q;
        src_d = src_q;
        if (acc_wr && frame_addr_in == ADDR_GEN)
        begin
            vth_d = frame_data_in[GEN_VTH_BIT];
            slew_d = frame_data_in[GEN_SLEW_LSB +: SLEW_W];
            div_d = frame_data_in[GEN_DIV_LSB +: DIV_W];
            src_d = frame_data_in[GEN_SRC_LSB +: SRC_W];
        end
        // Slew lands on a period boundary, or at once while run is off, to avoid a glitched gate edge
        slew_act_d = (dim_tick || !run_q) ? slew_q : slew_act_q;
        pend_d = (pend_q && !(dim_tick || !run_q))
            || (acc_wr && frame_addr_in == ADDR_GEN);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vth_q <= VTH_RST;
            slew_q <= SLEW_RST;
            slew_act_q <= SLEW_RST;
            div_q <= DIV_RST;
            src_q <= SRC_RST;
            pend_q <= 1'b0;
        end
        else if (ce_in)
        begin
            vth_q <= vth_d;
            slew_q <= slew_d;
            slew_act_q <= slew_act_d;
            div_q <= div_d;
            src_q <= src_d;
            pend_q <= pend_d;
        end
    end

    // Dimming counter and clock pin
    logic ext_edge, ext_slow, src_tick;
    logic [DIM_W-1:0] dim_cnt_d, dim_cnt_q;
    logic dim_cyc_d, dim_cyc_q, pin_d, pin_q, oe_d, oe_q;
    sdc_ext_clk_mon #(
        .LIMIT_CYCLES(EXT_LIMIT)
    ) u_ext_mon (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .pin_in(ext_clk_pin_in),
        .watch_in(src_q[SRC_EXT_BIT]),
        .edge_out(ext_edge),
        .slow_out(ext_slow)
    );

    always_comb
    begin
        src_tick = src_q[SRC_EXT_BIT] ? ext_edge : 1'b1;
        dim_tick = run_q && src_tick && (dim_cnt_q >= dim_last(div_q));
        dim_cnt_d = dim_cnt_q;
        if (!run_q || dim_tick)
            dim_cnt_d = '0;
        else if (src_tick)
            dim_cnt_d = dim_cnt_q + 1'b1;
        dim_cyc_d = dim_tick;
        // Internal reference leaves the pin at half the device clock
        oe_d = (src_d == SRC_INT_OUT);
        pin_d = oe_d ? ~pin_q : 1'b0;
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dim_cnt_q <= '0;
            dim_cyc_q <= 1'b0;
            pin_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (ce_in)
        begin
            dim_cnt_q <= dim_cnt_d;
            dim_cyc_q <= dim_cyc_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    // Frame answer
    logic acc_d, acc_q, rdv_d, rdv_q;
    logic [DATA_W-1:0] rdat_d, rdat_q;
    always_comb
    begin
        acc_d = acc;
        rdv_d = acc_rd;
        rdat_d = rdat_q;
        if (acc_rd)
        begin
            rdat_d = '0;
            // Flags go out as they stand, before the clear lands
            unique case (frame_addr_in)
                ADDR_RUN: rdat_d[RUN_EN_BIT] = run_q;
                ADDR_IFC: rdat_d = {cid_q, clk_err_q, crc_err_q, wr_err_q, rd_err_q, 1'b0,
                    cs_pu_q, sclk_pd_q, sdi_pd_q};
                ADDR_GEN: rdat_d = {4'h0, vth_q, 1'b0, slew_q, div_q, src_q};
            endcase
        end
    end
    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            acc_q <= 1'b0;
            rdv_q <= 1'b0;
            rdat_q <= '0;
        end
        else if (ce_in)
        begin
            acc_q <= acc_d;
            rdv_q <= rdv_d;
            rdat_q <= rdat_d;
        end
    end

    assign frame_accept_out = acc_q;
    assign rd_valid_out = rdv_q;
    assign rd_data_out = rdat_q;
    assign cluster_ident_out = cid_q;
    assign chip_select_pullup_en_out = cs_pu_q;
    assign sclk_pulldown_en_out = sclk_pd_q;
    assign serial_in_pulldown_en_out = sdi_pd_q;
    assign spi_err_out = spi_err_q;
    assign fault_threshold_select_out = vth_q;
    assign gate_slew_select_out = slew_act_q;
    assign dim_div_out = div_q;
    assign clk_src_out = src_q;
    assign clk_pin_out = pin_q;
    assign clk_pin_oe_out = oe_q;
    assign switch_run_enable_out = run_q;
    assign dim_cycle_out = dim_cyc_q;
    assign config_pending_out = pend_q;
    assign external_clock_slow_out = ext_slow;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);
    chk_cluster_gate: assert property (
        ce_in && frame_done_in && !edges_bad && !crc_bad && frame_cluster_in
        && frame_cid_in != cid_q |=> !frame_accept_out && !rd_valid_out)
        else $error("frame for another cluster was taken");
    chk_edge_count: assert property (
        ce_in && frame_done_in && frame_edges_in != FRAME_EDGES |=> clk_err_q && spi_err_out)
        else $error("bad edge count not flagged");
    chk_crc_reject: assert property (
        ce_in && frame_done_in && !edges_bad && !frame_crc_ok_in
        |=> crc_err_q && !frame_accept_out)
        else $error("failed crc frame not rejected");
    chk_read_data_zero: assert property (
        ce_in && live && !frame_write_in && frame_data_in != '0
        |=> wr_err_q && !rd_valid_out && !frame_accept_out)
        else $error("read with data not rejected");
    chk_flags_clear: assert property (
        ce_in && clr |=> !clk_err_q && !crc_err_q && !wr_err_q && !rd_err_q)
        else $error("error flags survive clearing read");
    chk_err_summary: assert property (
        spi_err_out == (clk_err_q | crc_err_q | wr_err_q | rd_err_q))
        else $error("summary error mismatch");
    chk_pull_write: assert property (
        ce_in && acc_wr && frame_addr_in == ADDR_IFC
        |=> chip_select_pullup_en_out == $past(frame_data_in[IFC_CS_BIT])
        && serial_in_pulldown_en_out == $past(frame_data_in[IFC_SDI_BIT]))
        else $error("pull enable write lost");
    chk_slew_boundary: assert property (
        !$stable(gate_slew_select_out) |-> $past(dim_tick || !run_q))
        else $error("slew changed mid period");
    chk_dim_wrap: assert property (
        ce_in && run_q && src_tick && dim_cnt_q == dim_last(div_q)
        |=> dim_cycle_out && dim_cnt_q == '0)
        else $error("dimming period end missed");
    chk_clk_pin_dir: assert property (
        clk_pin_oe_out == (clk_src_out == SRC_INT_OUT))
        else $error("clock pin direction wrong");
    chk_run_hold: assert property (
        ce_in && !switch_run_enable_out |=> dim_cnt_q == '0 && !dim_cycle_out)
        else $error("counter runs while stopped");
    chk_pending_set: assert property (
        ce_in && acc_wr && frame_addr_in == ADDR_GEN |=> config_pending_out)
        else $error("pending flag not raised");
    chk_slow_ext_only: assert property (
        external_clock_slow_out |-> $past(clk_src_out[SRC_EXT_BIT]))
        else $error("slow clock flagged with internal source");
    chk_error_kept: assert property (
        ce_in && evt_wr |=> wr_err_q)
        else $error("write reject flag lost");
    cov_clear_read: cover property (ce_in && clr && (clk_err_q || wr_err_q));
    cov_dim_cycle: cover property (dim_cycle_out && dim_div_out == 2'h1);
    cov_pending_done: cover property ($fell(config_pending_out));
endmodule

// ### rtl/sdc_pkg.sv
/*
 * Constants for the serial interface and dimming configuration registers:
 * register addresses, field positions, reset values and timing figures.
 * Assumes a 40 MHz device clock and an upstream serial front end that
 * presents each finished frame as one strobe with its decoded fields.
 */
package sdc_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 13;
    localparam int CID_W = 5;
    localparam int EDGE_W = 8;
    localparam int SLEW_W = 3;
    localparam int DIV_W = 2;
    localparam int SRC_W = 2;

    localparam logic [ADDR_W-1:0] ADDR_RUN = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_IFC = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_GEN = 6'h03;

    localparam int RUN_EN_BIT = 0;
    localparam int IFC_CID_LSB = 8;
    localparam int IFC_CLK_BIT = 7;
    localparam int IFC_CRC_BIT = 6;
    localparam int IFC_WR_BIT = 5;
    localparam int IFC_RD_BIT = 4;
    localparam int IFC_CS_BIT = 2;
    localparam int IFC_SCLK_BIT = 1;
    localparam int IFC_SDI_BIT = 0;
    localparam int GEN_VTH_BIT = 8;
    localparam int GEN_SLEW_LSB = 4;
    localparam int GEN_DIV_LSB = 2;
    localparam int GEN_SRC_LSB = 0;

    localparam logic [CID_W-1:0] CID_RST = 5'h01;
    localparam logic PULL_RST = 1'b1;
    localparam logic RUN_RST = 1'b0;
    localparam logic VTH_RST = 1'b0;
    localparam logic [SLEW_W-1:0] SLEW_RST = 3'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 2'h0;
    localparam logic [SRC_W-1:0] SRC_RST = 2'h0;

    localparam logic [EDGE_W-1:0] FRAME_EDGES = 8'h20;
    localparam logic [SRC_W-1:0] SRC_INT_OUT = 2'h1;
    localparam int SRC_EXT_BIT = 1;

    localparam int DIM_BASE_LOG2 = 12;
    localparam int MCLK_PERIOD_PS = 25000;
    localparam int EXT_MIN_PERIOD_NS = 10000;
    localparam int EXT_LIMIT_CYCLES = (EXT_MIN_PERIOD_NS * 1000) / MCLK_PERIOD_PS;
endpackage

// ### rtl/sdc_ext_clk_mon.sv
/*
 * External dimming clock monitor: synchronises the clock pin, emits one
 * pulse per rising edge and flags a clock whose period runs too long.
 * Assumes the pin toggles well below half the device clock rate.
 */
`timescale 1ns/1ps
module sdc_ext_clk_mon #(
    parameter int LIMIT_CYCLES = sdc_pkg::EXT_LIMIT_CYCLES
) (
    input wire logic mclk_in, // Device clock
    input wire logic rst_n_in, // Async reset, active low
    input wire logic ce_in, // Clock enable
    input wire logic pin_in, // Raw clock pin
    input wire logic watch_in, // External source selected
    output logic edge_out, // One pulse per rising edge
    output logic slow_out // Period too long
);
    import sdc_pkg::*;

    localparam int CNT_W = $clog2(LIMIT_CYCLES + 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(LIMIT_CYCLES);

    logic sync1_q, sync2_q, prev_q;
    logic edge_d, edge_q, slow_d, slow_q;
    logic [CNT_W-1:0] cnt_d, cnt_q;

    always_comb
    begin
        edge_d = sync2_q & ~prev_q;
        cnt_d = cnt_q;
        slow_d = slow_q;
        if (!watch_in || edge_d)
        begin
            cnt_d = '0;
            slow_d = 1'b0;
        end
        else if (cnt_q != LIMIT)
        begin
            cnt_d = cnt_q + 1'b1;
            slow_d = (cnt_d == LIMIT);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            edge_q <= 1'b0;
            slow_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (ce_in)
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            edge_q <= edge_d;
            slow_q <= slow_d;
            cnt_q <= cnt_d;
        end
    end

    assign edge_out = edge_q;
    assign slow_out = slow_q;

    chk_slow_needs_limit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        slow_q |-> (cnt_q == LIMIT))
        else $error("slow flag without full period count");
    cov_slow_seen: cover property (@(posedge mclk_in) disable iff (!rst_n_in) $rose(slow_q));
endmodule

// ### verification/sdc_frame_src.sv
/*
 * Frame source model: the master and serial front end as the register
 * block sees them. Assumes fields are taken on the rising clock edge.
 */
`timescale 1ns/1ps
module sdc_frame_src (
    input wire logic mclk_in, // Device clock
    input wire logic pend_in, // General config pending
    output logic done_out, // Frame end strobe
    output logic [7:0] edges_out, // Edge count
    output logic crc_out, // CRC good
    output logic wr_out, // Write frame
    output logic cl_out, // Cluster frame
    output logic [4:0] cid_out, // Cluster id
    output logic [5:0] addr_out, // Address
    output logic [12:0] data_out, // Data field
    output logic claim_out // Address owned elsewhere
);
    initial
    begin
        {done_out, edges_out, crc_out, wr_out, cl_out, cid_out, addr_out} = 23'h0;
        data_out = 13'h0;
        claim_out = 1'b0;
    end
    task automatic send(input logic w, c, input logic [4:0] id, input logic [5:0] a,
        input logic [12:0] d, input logic [7:0] e = 8'h20, input logic ok = 1'b1);
        int n;
        n = 0;
        // General writes wait out pending, which also spaces slew updates
        while (w && a == 6'h03 && pend_in === 1'b1 && n < 300)
        begin
            @(negedge mclk_in);
            n++;
        end
        @(negedge mclk_in);
        {wr_out, cl_out, cid_out, addr_out, data_out, edges_out, crc_out} = {w, c, id, a, d, e, ok};
        done_out = 1'b1;
        @(negedge mclk_in);
        done_out = 1'b0;
        data_out = ~d; // Stale field must not be reused
    endtask
    task automatic set_claim(input logic c);
        claim_out = c;
    endtask
endmodule

// ### verification/sdc_config_regs_tb.sv
/*
 * Self-checking bench for the configuration registers.
 * Assumes the package and the frame source model are compiled first.
 */
`timescale 1ns/1ps
module sdc_config_regs_tb;
    import sdc_pkg::*;
    logic clk, rst_n, pin, ext_on, fd, fcrc, fw, fcl, claim, acc, rdv, pu, pdc, pdd, err;
    logic fault_threshold_select, cpin, oe, run, dim, pend, slow, ce;
    logic [7:0] fe;
    logic [4:0] fcid, cluster_ident;
    logic [5:0] fa;
    logic [12:0] fdat, rdd, v;
    logic [2:0] slew;
    logic [1:0] div, src;
    int fail_count, check_count, hits;
    sdc_frame_src sdc_frame_src_i (.mclk_in(clk), .pend_in(pend), .done_out(fd),
        .edges_out(fe), .crc_out(fcrc), .wr_out(fw), .cl_out(fcl), .cid_out(fcid),
        .addr_out(fa), .data_out(fdat), .claim_out(claim));
    sdc_config_regs #(.DIM_LOG2(2), .EXT_LIMIT(20)) sdc_config_regs_i (.mclk_in(clk),
        .rst_n_in(rst_n), .ce_in(ce), .frame_done_in(fd), .frame_edges_in(fe),
        .frame_crc_ok_in(fcrc), .frame_write_in(fw), .frame_cluster_in(fcl),
        .frame_cid_in(fcid), .frame_addr_in(fa), .frame_data_in(fdat),
        .addr_claimed_in(claim), .ext_clk_pin_in(pin), .frame_accept_out(acc),
        .rd_valid_out(rdv), .rd_data_out(rdd), .cluster_ident_out(cluster_ident),
        .chip_select_pullup_en_out(pu), .sclk_pulldown_en_out(pdc),
        .serial_in_pulldown_en_out(pdd), .spi_err_out(err),
        .fault_threshold_select_out(fault_threshold_select), .gate_slew_select_out(slew), .dim_div_out(div),
        .clk_src_out(src), .clk_pin_out(cpin), .clk_pin_oe_out(oe),
        .switch_run_enable_out(run), .dim_cycle_out(dim), .config_pending_out(pend),
        .external_clock_slow_out(slow));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Pin edges land on falling clock edges, so the dimming period is exact
    always #100 if (ext_on) pin = ~pin;
    task automatic stop_test();
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] s, e);
        check_count++;
        if (s !== e)
        begin
            $display("[ERR] %s exp %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    task automatic rd(input logic [5:0] a, input logic [12:0] e);
        sdc_frame_src_i.send(1'b0, 1'b0, 5'h00, a, 13'h0000);
        check("read", {2'b00, rdv, rdd}, {3'h1, e});
    endtask
    task automatic wr(input logic [5:0] a, input logic [12:0] d);
        sdc_frame_src_i.send(1'b1, 1'b0, 5'h00, a, d);
    endtask
    task automatic period(input int e);
        int n;
        n = 0;
        while (dim !== 1'b1 && n < 99) @(negedge clk) n++;
        @(negedge clk) n = 1;
        while (dim !== 1'b1 && n < 99) @(negedge clk) n++;
        check("period", n[15:0], e[15:0]);
    endtask
    task automatic t_reset();
        check("pulls", {pu, pdc, pdd}, 16'h7);
        check("cid", cluster_ident, 16'h1);
        rd(ADDR_IFC, 13'h0107);
        rd(ADDR_GEN, 13'h0000);
    endtask
    task automatic t_err();
        sdc_frame_src_i.send(1'b0, 1'b0, 5'h00, ADDR_IFC, 13'h0, 8'h21, 1'b0);
        check("err", err, 16'h1);
        rd(ADDR_IFC, 13'h0187);
        sdc_frame_src_i.send(1'b0, 1'b0, 5'h00, ADDR_IFC, 13'h0, 8'h20, 1'b0);
        rd(ADDR_IFC, 13'h0147);
        wr(6'h3F, 13'h0001);
        sdc_frame_src_i.send(1'b0, 1'b0, 5'h00, ADDR_GEN, 13'h1000);
        rd(ADDR_IFC, 13'h0127);
        sdc_frame_src_i.send(1'b0, 1'b0, 5'h00, 6'h3E, 13'h0000);
        rd(ADDR_IFC, 13'h0117);
        check("err", err, 16'h0);
        sdc_frame_src_i.set_claim(1'b1);
        wr(6'h3F, 13'h0001);
        check("claim", {acc, rdv}, 16'h2);
        sdc_frame_src_i.set_claim(1'b0);
        rd(ADDR_IFC, 13'h0107);
    endtask
    task automatic t_cid();
        wr(ADDR_IFC, 13'h0500);
        check("cid_pulls", {cluster_ident, pu, pdc, pdd}, 16'h28);
        sdc_frame_src_i.send(1'b1, 1'b1, 5'h03, ADDR_IFC, 13'h01FF);
        check("accept", acc, 16'h0);
        sdc_frame_src_i.send(1'b1, 1'b1, 5'h05, ADDR_IFC, 13'h01FF);
        check("accept", acc, 16'h1);
        rd(ADDR_IFC, 13'h0107);
    endtask
    task automatic t_gen();
        for (int s = 0; s < 4; s++)
        begin
            v = {4'h0, 1'b1, 6'h00, s[1:0]};
            wr(ADDR_GEN, v);
            check("oe_src", {oe, fault_threshold_select, src}, {12'h0, s == 1, 1'b1, s[1:0]});
            hits = int'(cpin);
            @(negedge clk);
            check("pin", {hits[0], cpin}, (s == 1) ? {hits[0], ~hits[0]} : 2'h0);
            rd(ADDR_GEN, v);
        end
    endtask
    task automatic t_dim();
        wr(ADDR_RUN, 13'h0001);
        for (int d = 0; d < 4; d++)
        begin
            wr(ADDR_GEN, {9'h000, d[1:0], 2'h0});
            check("div", div, d[15:0]);
            period(4 << d);
        end
        wr(ADDR_GEN, 13'h0050);
        check("pend_slew", {pend, slew}, 16'h8);
        period(4);
        check("pend_slew", {pend, slew}, 16'h5);
        wr(ADDR_RUN, 13'h0000);
        hits = 0;
        repeat (40) @(negedge clk) hits += int'(dim === 1'b1);
        check("idle", {run, hits[14:0]}, 16'h0);
        wr(ADDR_RUN, 13'h0001);
        period(4);
    endtask
    task automatic t_ext();
        wr(ADDR_GEN, 13'h0002);
        check("oe", oe, 16'h0);
        repeat (30) @(negedge clk);
        check("slow", slow, 16'h1);
        ext_on = 1'b1;
        period(32);
        check("slow", slow, 16'h0);
    endtask
    task automatic t_ce();
        ce = 1'b0;
        wr(ADDR_RUN, 13'h0000);
        check("ce_hold", {acc, run}, 16'h1);
        ce = 1'b1;
        wr(ADDR_RUN, 13'h0000);
        check("ce_run", {acc, run}, 16'h2);
    endtask
    initial
    begin
        {rst_n, pin, ext_on, fail_count, check_count} = '0;
        ce = 1'b1;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_err();
        t_cid();
        t_gen();
        t_dim();
        t_ext();
        t_ce();
        stop_test();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
